// File: hw/osf_defs.svh
// constants for the outgoing stream formatter
`ifndef OSF_DEFS_SVH
`define OSF_DEFS_SVH
`define OSF_PTR_OFFSET 10'h20a
`define OSF_NDF_NORMAL 4'h6
`define OSF_SS_BITS 2'h0
`define OSF_BYTE_ZERO 8'h00
`define OSF_NIB_ZERO 4'h0
`define OSF_CFG_WAIT 2'h3
`define OSF_CNT_ONE 2'h1
`endif

// File: hw/osf_pkg.sv
// types shared by the outgoing stream formatter
package osf_pkg;
  typedef enum logic {
    OSF_UPPER,
    OSF_LOWER
  } osf_phase_e;
endpackage

// File: hw/osf_sync2.sv
// two flip-flop synchroniser for one level
`timescale 1ns/1ps
module osf_sync2 (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // level in and out
  input wire logic async,
  output logic synced
);
  logic stage;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      stage <= 1'b0;
      synced <= 1'b0;
    end else begin
      stage <= async;
      synced <= stage;
    end
  end
endmodule

// File: hw/osf_formatter.sv
// outgoing stream formatter: byte or nibble bus with parity and tributary markers
//
// How it works
// - in byte mode serial bit 1 goes out on bus bit 7 and serial bit 8 on bus bit 0.
// - in nibble mode each byte leaves as upper then lower nibble on bus lines 3..0.
// - in nibble mode bus lines 7..4 are held low all the time.
// - in locked mode overhead bytes are zero except H1 and H2 carrying pointer 522.
// - the data bus updates on the byte clock in byte mode and the nibble clock in nibble mode.
// - a parity bit covers the bus, odd when the select input is high, even when low.
// - the parity bit updates on the same clock as the data bus.
// - the payload marker is high for every byte that carries tributary payload.
// - in locked mode the payload marker is low during transport overhead.
// - the V5 marker is high on each tributary V5 byte.
// - for a TU3 the V5 marker flags the TU3 J1 byte instead.
// - in locked mode the V5 marker is low during transport overhead.
// - both markers update with the data bus once per byte; in nibble mode only with the upper nibble.
// - in locked mode the container is aligned so that J1 directly follows C1.
`timescale 1ns/1ps
`include "osf_defs.svh"
module osf_formatter (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // static configuration
  input wire logic out_width_select,
  input wire logic odd_parity_select,
  input wire logic lockedMode,
  input wire logic tu3Mode,
  // nibble clock pin
  input wire logic half_byte_clock,
  // byte stream from the payload side
  input wire logic [7:0] inByte,
  input wire logic inOverhead,
  input wire logic inH1,
  input wire logic inH2,
  input wire logic inC1,
  input wire logic inTribPayload,
  input wire logic inVfive,
  input wire logic inTu3J1,
  input wire logic payload_active_in,
  // outgoing stream
  output logic [7:0] out_data_bus,
  output logic out_parity_bit,
  output logic trib_payload_marker,
  output logic trib_vfive_marker,
  // pacing back to the payload side
  output logic byteTake,
  output logic lockJ1Slot,
  output logic byteMode
);
  logic nibClkSync;
  logic nibClkPrev;
  logic widthSync;
  logic cfgLoaded;
  logic [1:0] cfgCnt;
  osf_pkg::osf_phase_e phase;
  logic [3:0] heldLow;
  logic updated;

  osf_sync2 u_nib_sync (
    .clk(clk),
    .rst_b(rst_b),
    .async(half_byte_clock),
    .synced(nibClkSync)
  );

  osf_sync2 u_width_sync (
    .clk(clk),
    .rst_b(rst_b),
    .async(out_width_select),
    .synced(widthSync)
  );

  // width is strapped: capture once after the synchroniser has settled
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cfgCnt <= 2'h0;
      cfgLoaded <= 1'b0;
      byteMode <= 1'b1;
    end else if (!cfgLoaded) begin
      cfgCnt <= cfgCnt + `OSF_CNT_ONE;
      if (cfgCnt == `OSF_CFG_WAIT) begin
        cfgLoaded <= 1'b1;
        byteMode <= widthSync;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      nibClkPrev <= 1'b0;
    end else begin
      nibClkPrev <= nibClkSync;
    end
  end

  // nothing leaves before the width is known, so a mode switch never tears a byte
  wire nibEdge = nibClkSync & ~nibClkPrev;
  wire update = cfgLoaded & (byteMode | nibEdge);
  wire takeNow = update & (byteMode | (phase == osf_pkg::OSF_UPPER));

  // locked overhead substitution; floating overhead passes through and the far end ignores it
  wire lockOh = lockedMode & inOverhead;
  wire [9:0] ptrVal = `OSF_PTR_OFFSET;
  wire [7:0] h1Byte = {`OSF_NDF_NORMAL, `OSF_SS_BITS, ptrVal[9:8]};
  wire [7:0] h2Byte = ptrVal[7:0];
  wire [7:0] ohByte = inH1 ? h1Byte : (inH2 ? h2Byte : `OSF_BYTE_ZERO);
  // payload_active_in is only meaningful for floating upstream framing; data comes pre-marked
  wire [7:0] selByte = lockOh ? ohByte : inByte;
  wire selTpl = inTribPayload & ~lockOh;
  wire selV5 = (tu3Mode ? inTu3J1 : inVfive) & ~lockOh;

  wire [7:0] upperBus = {`OSF_NIB_ZERO, selByte[7:4]};
  wire [7:0] lowerBus = {`OSF_NIB_ZERO, heldLow};
  wire [7:0] next_bus = byteMode ? selByte : ((phase == osf_pkg::OSF_UPPER) ? upperBus : lowerBus);
  wire next_parity = (^next_bus) ^ odd_parity_select;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      out_data_bus <= `OSF_BYTE_ZERO;
      out_parity_bit <= 1'b0;
    end else if (update) begin
      out_data_bus <= next_bus;
      out_parity_bit <= next_parity;
    end
  end

  // markers are per byte, so they hold across the lower nibble
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      trib_payload_marker <= 1'b0;
      trib_vfive_marker <= 1'b0;
    end else if (takeNow) begin
      trib_payload_marker <= selTpl;
      trib_vfive_marker <= selV5;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      phase <= osf_pkg::OSF_UPPER;
      heldLow <= `OSF_NIB_ZERO;
    end else if (update && !byteMode) begin
      case (phase)
        osf_pkg::OSF_UPPER: begin
          heldLow <= selByte[3:0];
          phase <= osf_pkg::OSF_LOWER;
        end
        default: begin
          phase <= osf_pkg::OSF_UPPER;
        end
      endcase
    end
  end

  // the source advances one byte per take; a J1 slot follows a taken C1 in locked mode
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      byteTake <= 1'b0;
      lockJ1Slot <= 1'b0;
      updated <= 1'b0;
    end else begin
      byteTake <= takeNow;
      lockJ1Slot <= takeNow & lockedMode & inC1;
      updated <= update;
    end
  end

  // bit order and nibble split
  a_byte_order: assert property (@(posedge clk) disable iff (!rst_b)
    (cfgLoaded && byteMode && !lockOh) |=> (out_data_bus == $past(inByte)))
    else $error("byte bus does not carry the source byte in bit order");

  a_nib_upper: assert property (@(posedge clk) disable iff (!rst_b)
    (takeNow && !byteMode && !lockOh) |=> (out_data_bus[3:0] == $past(inByte[7:4])))
    else $error("upper nibble not sent first");

  a_nib_keep: assert property (@(posedge clk) disable iff (!rst_b)
    (takeNow && !byteMode && !lockOh) |=> (heldLow == $past(inByte[3:0])))
    else $error("lower nibble not kept for the second half");

  a_nib_lower: assert property (@(posedge clk) disable iff (!rst_b)
    (update && !byteMode && (phase == osf_pkg::OSF_LOWER)) |=>
    (out_data_bus == {`OSF_NIB_ZERO, $past(heldLow)}))
    else $error("lower nibble not sent second");

  a_nib_phase: assert property (@(posedge clk) disable iff (!rst_b)
    (update && !byteMode) |=> (phase != $past(phase)))
    else $error("nibble halves do not alternate");

  a_nib_high_low: assert property (@(posedge clk) disable iff (!rst_b)
    (cfgLoaded && !byteMode) |-> (out_data_bus[7:4] == `OSF_NIB_ZERO))
    else $error("upper bus lines not low in nibble mode");

  // locked overhead substitution
  a_lock_zero: assert property (@(posedge clk) disable iff (!rst_b)
    (cfgLoaded && byteMode && lockOh && !inH1 && !inH2) |=> (out_data_bus == `OSF_BYTE_ZERO))
    else $error("locked overhead byte not zero");

  a_lock_nib_zero: assert property (@(posedge clk) disable iff (!rst_b)
    (takeNow && !byteMode && lockOh && !inH1 && !inH2) |=> (out_data_bus == `OSF_BYTE_ZERO))
    else $error("locked overhead nibble not zero");

  a_lock_ptr: assert property (@(posedge clk) disable iff (!rst_b)
    (cfgLoaded && byteMode && lockOh && inH1) ##1 (lockOh && inH2) |->
    (out_data_bus[1:0] == 2'h2) ##1 (out_data_bus == 8'h0a))
    else $error("locked pointer is not 522");

  a_lock_h1: assert property (@(posedge clk) disable iff (!rst_b)
    (takeNow && byteMode && lockOh && inH1) |=>
    (out_data_bus == {`OSF_NDF_NORMAL, `OSF_SS_BITS, 2'h2}))
    else $error("locked H1 byte does not carry the pointer");

  a_lock_h2: assert property (@(posedge clk) disable iff (!rst_b)
    (takeNow && byteMode && lockOh && inH2 && !inH1) |=> (out_data_bus == 8'h0a))
    else $error("locked H2 byte does not carry the pointer");

  a_lock_nib_ptr: assert property (@(posedge clk) disable iff (!rst_b)
    (takeNow && !byteMode && lockOh && inH1) |=> (out_data_bus[3:0] == `OSF_NDF_NORMAL))
    else $error("locked H1 upper nibble wrong");

  // update timing
  a_hold_between: assert property (@(posedge clk) disable iff (!rst_b)
    (cfgLoaded && !byteMode && !nibEdge) |=>
    ($stable(out_data_bus) && $stable(out_parity_bit) && $stable(trib_vfive_marker)))
    else $error("outputs moved without a nibble clock edge");

  a_byte_every: assert property (@(posedge clk) disable iff (!rst_b)
    (cfgLoaded && byteMode) |=> byteTake)
    else $error("byte mode skipped a byte");

  a_idle_before: assert property (@(posedge clk) disable iff (!rst_b)
    !cfgLoaded |=> (!byteTake && (out_data_bus == `OSF_BYTE_ZERO)))
    else $error("stream moved before the width was captured");

  // parity
  a_parity_bus: assert property (@(posedge clk) disable iff (!rst_b)
    updated |-> (out_parity_bit == ((^out_data_bus) ^ $past(odd_parity_select))))
    else $error("parity does not match bus and select");

  // markers
  a_payload_mark: assert property (@(posedge clk) disable iff (!rst_b)
    (cfgLoaded && byteMode) |=> (trib_payload_marker == $past(inTribPayload & ~lockOh)))
    else $error("payload marker wrong");

  a_nib_payload: assert property (@(posedge clk) disable iff (!rst_b)
    (takeNow && !byteMode) |=> (trib_payload_marker == $past(inTribPayload & ~lockOh)))
    else $error("payload marker wrong in nibble mode");

  a_lock_markers: assert property (@(posedge clk) disable iff (!rst_b)
    (takeNow && lockOh) |=> (!trib_payload_marker && !trib_vfive_marker))
    else $error("marker high in locked overhead");

  a_tu3_j1: assert property (@(posedge clk) disable iff (!rst_b)
    (takeNow && tu3Mode && !lockOh) |=> (trib_vfive_marker == $past(inTu3J1)))
    else $error("TU3 J1 not flagged on the V5 marker");

  a_vfive_mark: assert property (@(posedge clk) disable iff (!rst_b)
    (takeNow && !tu3Mode && !lockOh) |=> (trib_vfive_marker == $past(inVfive)))
    else $error("V5 marker wrong");

  a_marks_hold: assert property (@(posedge clk) disable iff (!rst_b)
    (cfgLoaded && !takeNow) |=> ($stable(trib_payload_marker) && $stable(trib_vfive_marker)))
    else $error("markers moved on the lower nibble");

  // alignment and configuration
  a_j1_slot: assert property (@(posedge clk) disable iff (!rst_b)
    (takeNow && lockedMode && inC1) |=> lockJ1Slot ##1 !lockJ1Slot)
    else $error("J1 slot not flagged once after C1");

  a_slot_float: assert property (@(posedge clk) disable iff (!rst_b)
    !lockedMode |=> !lockJ1Slot)
    else $error("J1 slot flagged outside locked mode");

  a_width_static: assert property (@(posedge clk) disable iff (!rst_b)
    cfgLoaded |=> ($stable(byteMode) && cfgLoaded))
    else $error("width mode changed after capture");
endmodule

// File: tb/osf_nib_sink.sv
// downstream model: nibble clock source and nibble reassembly
`timescale 1ns/1ps
module osf_nib_sink (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // stream in
  input wire logic run,
  input wire logic [7:0] out_data_bus,
  input wire logic byteTake,
  // nibble clock and rebuilt byte
  output logic half_byte_clock,
  output logic [7:0] rxByte,
  output logic rxDone
);
  logic [2:0] cnt;
  logic [3:0] dly;
  // idles low between frames; 4 high and 4 low leaves sync margin
  assign half_byte_clock = cnt[2];
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt <= 3'h0;
      dly <= 4'h0;
      rxByte <= 8'h00;
      rxDone <= 1'b0;
    end else begin
      if (run || cnt != 3'h0) begin
        cnt <= cnt + 3'h1;
      end
      rxDone <= (dly == 4'h1);
      if (byteTake) begin
        dly <= 4'hc;
        rxByte[7:4] <= out_data_bus[3:0];
      end else if (dly != 4'h0) begin
        dly <= dly - 4'h1;
      end
      // mid-nibble sample, clear of the sync jitter
      if (dly == 4'h1) begin
        rxByte[3:0] <= out_data_bus[3:0];
      end
    end
  end
endmodule

// File: tb/osf_formatter_tb.sv
// self-checking bench for the outgoing stream formatter
`timescale 1ns/1ps
`include "osf_defs.svh"
module osf_formatter_tb;
  localparam logic [9:0] PTR = 10'h20a;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic wid = 1'b1;
  logic odd = 1'b0;
  logic lck = 1'b0;
  logic tu3 = 1'b0;
  logic run = 1'b0;
  logic [7:0] inB = 8'h00;
  logic [6:0] f = 7'h00;
  logic [7:0] bus;
  logic [7:0] rxB;
  logic par, tp, v5, take, j1s, bm, hbc, rxDone, pay;
  int err_count = 0;
  int n_checks = 0;
  assign pay = !lck && !f[6];
  initial begin
    forever #5 clk = ~clk;
  end
  osf_formatter osf_formatter_i (.clk(clk), .rst_b(rst_b), .out_width_select(wid),
    .odd_parity_select(odd), .lockedMode(lck), .tu3Mode(tu3), .half_byte_clock(hbc),
    .inByte(inB), .inOverhead(f[6]), .inH1(f[5]), .inH2(f[4]), .inC1(f[3]),
    .inTribPayload(f[2]), .inVfive(f[1]), .inTu3J1(f[0]), .payload_active_in(pay),
    .out_data_bus(bus), .out_parity_bit(par), .trib_payload_marker(tp),
    .trib_vfive_marker(v5), .byteTake(take), .lockJ1Slot(j1s), .byteMode(bm));
  osf_nib_sink osf_nib_sink_i (.clk(clk), .rst_b(rst_b), .run(run), .out_data_bus(bus),
    .byteTake(take), .half_byte_clock(hbc), .rxByte(rxB), .rxDone(rxDone));
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic step;
    @(posedge clk);
    #1;
  endtask
  // fl holds overhead, H1, H2, C1, payload, V5, TU3 J1
  task automatic xfer(input logic [7:0] b, input logic [6:0] fl);
    logic oh;
    logic [7:0] d;
    int k;
    oh = lck && fl[6];
    d = !oh ? b : fl[5] ? {`OSF_NDF_NORMAL, `OSF_SS_BITS, PTR[9:8]} : fl[4] ? PTR[7:0] : 8'h00;
    inB = b;
    f = fl;
    k = 0;
    step;
    while (take !== 1'b1 && k < 40) begin
      step;
      k++;
    end
    chk("take", {7'h0, take}, 8'h01);
    if (wid) begin
      chk("bus", bus, d);
      chk("parity", {7'h0, par}, {7'h0, ^d ^ odd});
    end else begin
      chk("upper", bus, {4'h0, d[7:4]});
      chk("parity", {7'h0, par}, {7'h0, ^d[7:4] ^ odd});
    end
    chk("payload", {7'h0, tp}, {7'h0, fl[2] & !oh});
    chk("vfive", {7'h0, v5}, {7'h0, !oh & (tu3 ? fl[0] : fl[1])});
    chk("j1slot", {7'h0, j1s}, {7'h0, lck & fl[3]});
    if (!wid) begin
      k = 0;
      while (rxDone !== 1'b1 && k < 40) begin
        step;
        k++;
      end
      chk("byte", rxB, d);
      chk("lower", bus, {4'h0, d[3:0]});
      chk("parity", {7'h0, par}, {7'h0, ^d[3:0] ^ odd});
    end
  endtask
  task automatic start(input logic w);
    rst_b = 1'b0;
    wid = w;
    run = !w;
    repeat (20) step;
    rst_b = 1'b1;
    repeat (6) step;
    chk("width", {7'h0, bm}, {7'h0, w});
  endtask
  task automatic test_byte;
    start(1'b1);
    for (int i = 0; i < 2; i++) begin
      odd = i[0];
      xfer(8'h80, 7'h00);
      xfer(8'h01, 7'h00);
      xfer(8'ha5, 7'h04);
    end
    $display("test_byte done");
  endtask
  task automatic test_marks;
    for (int i = 0; i < 8; i++) begin
      tu3 = i[2];
      xfer(8'h3c, {4'h0, i[2:0]});
    end
    $display("test_marks done");
  endtask
  task automatic test_locked;
    tu3 = 1'b0;
    for (int i = 0; i < 2; i++) begin
      lck = i[0];
      xfer(8'hff, 7'h47);
      xfer(8'hee, 7'h60);
      xfer(8'hdd, 7'h50);
      xfer(8'h9c, 7'h48);
      xfer(8'h11, 7'h00);
    end
    $display("test_locked done");
  endtask
  task automatic test_nibble;
    lck = 1'b0;
    start(1'b0);
    xfer(8'h96, 7'h04);
    odd = 1'b1;
    xfer(8'h5a, 7'h02);
    lck = 1'b1;
    xfer(8'hff, 7'h60);
    xfer(8'h77, 7'h47);
    xfer(8'h9c, 7'h48);
    $display("test_nibble done");
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    test_byte;
    test_marks;
    test_locked;
    test_nibble;
    print_verdict;
  end
  // whole run is near 150 cycles
  initial begin
    #50us;
    err_count++;
    print_verdict;
  end
endmodule
